//--- rtl/multiply_add_slice_cfg.svh
// Widths, field positions, reset values and number formats of the slice.
`ifndef MULTIPLY_ADD_SLICE_CFG_SVH
`define MULTIPLY_ADD_SLICE_CFG_SVH

`define MAS_A_W       19
`define MAS_B_W       18
`define MAS_R_W       48
`define MAS_SH_W      4
`define MAS_D0_AW     11
`define MAS_D0_BW     10
`define MAS_D1_W      8
`define MAS_D_R_W     24
`define MAS_Q0_AW     7
`define MAS_Q0_BW     6
`define MAS_QN_W      4
`define MAS_Q_R_W     12
`define MAS_QN_LANES  3
`define MAS_RESULT_RST 48'h0000_0000_0000
`define MAS_VALID_RST 1'b0
`define MAS_BF_W      16
`define MAS_BF_BIAS   11'sd127
`define MAS_BF_EXP_MAX 8'hFF
`define MAS_BF_NAN    16'h7FC0
`define MAS_BF_POINT  38

`endif

//--- rtl/multiply_add_slice_pkg.sv
// Types shared by the multiply-add slice modules.
`include "multiply_add_slice_cfg.svh"

package multiply_add_slice_pkg;

    typedef enum logic [1:0] {
        MODE_NORMAL = 2'h0,
        MODE_DUAL   = 2'h1,
        MODE_QUAD   = 2'h2,
        MODE_FLOAT  = 2'h3
    } slice_mode_t;

    typedef struct packed {
        logic [`MAS_R_W-1:0] result;
        logic                valid;
    } slice_state_t;

endpackage

//--- rtl/lane_ctrl_if.sv
// Per-operation controls shared by every integer lane of the slice.
`timescale 1ns/1ps
`include "multiply_add_slice_cfg.svh"

interface lane_ctrl_if;
    logic                 useAdder;
    logic                 subtract;
    logic                 accumulate;
    logic [`MAS_SH_W-1:0] shiftAmt;

    modport ctrl (
        output useAdder,
        output subtract,
        output accumulate,
        output shiftAmt
    );

    modport lane (
        input useAdder,
        input subtract,
        input accumulate,
        input shiftAmt
    );
endinterface

//--- rtl/mac_lane.sv
// One integer multiply, add/subtract/accumulate and right-shift lane.
`timescale 1ns/1ps
`include "multiply_add_slice_cfg.svh"

module mac_lane #(
    parameter int AW         = 4,
    parameter int BW         = 4,
    parameter int W          = 12,
    parameter bit SIGNED_OPS = 1'b1
) (
    lane_ctrl_if.lane        ctl,
    input  wire logic [AW-1:0] a,
    input  wire logic [BW-1:0] b,
    input  wire logic [W-1:0]  addend,
    input  wire logic [W-1:0]  accIn,
    output logic      [W-1:0]  laneOut
);
    localparam int PW = AW + BW + 2;
    localparam int EW = (W > PW) ? W : PW;

    logic signed [PW-1:0] prodFull;
    logic signed [EW-1:0] prodExt;
    logic        [W-1:0]  prod;
    logic        [W-1:0]  base;
    logic        [W-1:0]  sum;

    always_comb begin
        // The extra top bit is a sign copy or a zero, so one signed
        // multiplier serves both operand formats.
        prodFull = $signed({SIGNED_OPS & a[AW-1], a})
                 * $signed({SIGNED_OPS & b[BW-1], b});
        prodExt  = EW'(prodFull);
        // Narrow lanes keep only the low W bits of the product.
        prod     = prodExt[W-1:0];
        base     = ctl.accumulate ? accIn : addend;
        if (!(ctl.useAdder || ctl.accumulate)) begin
            sum = prod;
        end else if (ctl.subtract) begin
            sum = base - prod;
        end else begin
            sum = base + prod;
        end
        if (SIGNED_OPS) begin
            laneOut = W'($signed(sum) >>> ctl.shiftAmt);
        end else begin
            laneOut = sum >> ctl.shiftAmt;
        end
    end
endmodule // mac_lane

//--- rtl/multiply_add_slice.sv
// Configurable multiply-add slice: integer lanes and bfloat16 FMA.
//
// Functional notes
// - Four modes; one active; each partitions multipliers.
// - Normal: one 19x18 product, 48-bit add/sub.
// - Dual: 11x10 and 8x8, each 24-bit.
// - Quad: 7x6 and three 4x4, 12-bit each.
// - Quad 7x6 product truncated to 12 bits.
// - Float: bfloat16 FMA, single final rounding.
// - 4-bit right shift per lane of integer modes; not float.
// - Supports add, subtract and running accumulation.
// - Static parameter selects signed or unsigned operands.
// - Operands A and B; product bypasses adder optionally.
`timescale 1ns/1ps
`include "multiply_add_slice_cfg.svh"

module multiply_add_slice #(
    parameter bit SIGNED_OPS = 1'b1
) (
    input  wire logic                              sys_clk,
    input  wire logic                              reset,
    input  wire logic                              opEnable,
    input  wire multiply_add_slice_pkg::slice_mode_t mode,
    input  wire logic [`MAS_A_W-1:0]               opA,
    input  wire logic [`MAS_B_W-1:0]               opB,
    input  wire logic [`MAS_R_W-1:0]               addend,
    input  wire logic                              useAdder,
    input  wire logic                              subtract,
    input  wire logic                              accumulate,
    input  wire logic [`MAS_SH_W-1:0]              shiftAmt,
    output logic      [`MAS_R_W-1:0]               result,
    output logic                                   resultValid
);
    import multiply_add_slice_pkg::*;

    localparam int QW = `MAS_Q_R_W;
    localparam int DW = `MAS_D_R_W;

    slice_state_t st_reg;
    slice_state_t st_next;

    lane_ctrl_if ctl ();

    logic [`MAS_R_W-1:0]   normOut;
    logic [2*DW-1:0]       dualOut;
    logic [4*QW-1:0]       quadOut;
    logic [`MAS_BF_W-1:0]  fltOut;

    assign ctl.useAdder   = useAdder;
    assign ctl.subtract   = subtract;
    assign ctl.accumulate = accumulate;
    assign ctl.shiftAmt   = shiftAmt;

    // The single wide lane of normal mode.
    mac_lane #(
        .AW         (`MAS_A_W),
        .BW         (`MAS_B_W),
        .W          (`MAS_R_W),
        .SIGNED_OPS (SIGNED_OPS)
    ) u_norm (
        .ctl     (ctl),
        .a       (opA),
        .b       (opB),
        .addend  (addend),
        .accIn   (st_reg.result),
        .laneOut (normOut)
    );

    // Dual mode: the wider lane sits in the low bits of A, B and result.
    mac_lane #(
        .AW         (`MAS_D0_AW),
        .BW         (`MAS_D0_BW),
        .W          (DW),
        .SIGNED_OPS (SIGNED_OPS)
    ) u_dual0 (
        .ctl     (ctl),
        .a       (opA[`MAS_D0_AW-1:0]),
        .b       (opB[`MAS_D0_BW-1:0]),
        .addend  (addend[DW-1:0]),
        .accIn   (st_reg.result[DW-1:0]),
        .laneOut (dualOut[DW-1:0])
    );

    mac_lane #(
        .AW         (`MAS_D1_W),
        .BW         (`MAS_D1_W),
        .W          (DW),
        .SIGNED_OPS (SIGNED_OPS)
    ) u_dual1 (
        .ctl     (ctl),
        .a       (opA[`MAS_D0_AW +: `MAS_D1_W]),
        .b       (opB[`MAS_D0_BW +: `MAS_D1_W]),
        .addend  (addend[DW +: DW]),
        .accIn   (st_reg.result[DW +: DW]),
        .laneOut (dualOut[DW +: DW])
    );

    // Quad mode: the 7x6 lane is squeezed into a 12-bit result.
    mac_lane #(
        .AW         (`MAS_Q0_AW),
        .BW         (`MAS_Q0_BW),
        .W          (QW),
        .SIGNED_OPS (SIGNED_OPS)
    ) u_quad0 (
        .ctl     (ctl),
        .a       (opA[`MAS_Q0_AW-1:0]),
        .b       (opB[`MAS_Q0_BW-1:0]),
        .addend  (addend[QW-1:0]),
        .accIn   (st_reg.result[QW-1:0]),
        .laneOut (quadOut[QW-1:0])
    );

    for (genvar i = 0; i < `MAS_QN_LANES; i++) begin : g_quad
        mac_lane #(
            .AW         (`MAS_QN_W),
            .BW         (`MAS_QN_W),
            .W          (QW),
            .SIGNED_OPS (SIGNED_OPS)
        ) u_quadn (
            .ctl     (ctl),
            .a       (opA[`MAS_Q0_AW + `MAS_QN_W*i +: `MAS_QN_W]),
            .b       (opB[`MAS_Q0_BW + `MAS_QN_W*i +: `MAS_QN_W]),
            .addend  (addend[QW*(i+1) +: QW]),
            .accIn   (st_reg.result[QW*(i+1) +: QW]),
            .laneOut (quadOut[QW*(i+1) +: QW])
        );
    end

    // bfloat16 fused multiply-add datapath.
    logic               fSa;
    logic               fSb;
    logic               fSc;
    logic               fSp;
    logic [7:0]         fEa;
    logic [7:0]         fEb;
    logic [7:0]         fEc;
    logic [15:0]        fC;
    logic               pZero;
    logic               cZero;
    logic               special;
    logic [15:0]        fPm;
    logic [15:0]        fCm;
    logic signed [10:0] fEp;
    logic signed [10:0] fEbig;
    logic signed [10:0] fEsml;
    logic signed [10:0] fExp;
    logic [10:0]        fDiff;
    logic [5:0]         fSh;
    logic               pBig;
    logic [39:0]        bigSig;
    logic [39:0]        smlSig;
    logic               bigSgn;
    logic               smlSgn;
    logic [79:0]        alTmp;
    logic [39:0]        smlAl;
    logic [40:0]        fMag;
    logic               fSgn;
    logic [5:0]         fLead;
    logic [40:0]        fNorm;
    logic               rndUp;
    logic [8:0]         fMant;

    always_comb begin
        fC    = (accumulate ? st_reg.result[`MAS_BF_W-1:0]
                            : addend[`MAS_BF_W-1:0]);
        fSa   = opA[15];
        fSb   = opB[15];
        fSc   = fC[15];
        fEa   = opA[14:7];
        fEb   = opB[14:7];
        fEc   = fC[14:7];
        fSp   = fSa ^ fSb ^ subtract;
        pZero = (fEa == 8'h00) || (fEb == 8'h00);
        // Without the adder the product is rounded on its own.
        cZero = (fEc == 8'h00) || !(useAdder || accumulate);
        special = (fEa == `MAS_BF_EXP_MAX) || (fEb == `MAS_BF_EXP_MAX)
               || ((fEc == `MAS_BF_EXP_MAX) && !cZero);
        // The full 16-bit significand product is kept: no rounding here.
        fPm   = {1'b1, opA[6:0]} * {1'b1, opB[6:0]};
        fCm   = {1'b1, fC[6:0], 7'h00};
        fEp   = $signed({3'b000, fEa}) + $signed({3'b000, fEb})
              - `MAS_BF_BIAS;
        pBig  = !pZero && (cZero || (fEp >= $signed({3'b000, fEc})));
        if (pBig) begin
            bigSig = {fPm, 24'h000000};
            bigSgn = fSp;
            fEbig  = fEp;
            smlSig = cZero ? 40'h0 : {fCm, 24'h000000};
            smlSgn = fSc;
            fEsml  = $signed({3'b000, fEc});
        end else begin
            bigSig = cZero ? 40'h0 : {fCm, 24'h000000};
            bigSgn = fSc;
            fEbig  = $signed({3'b000, fEc});
            smlSig = pZero ? 40'h0 : {fPm, 24'h000000};
            smlSgn = fSp;
            fEsml  = fEp;
        end
        fDiff = 11'(fEbig - fEsml);
        fSh   = (fDiff > 11'd63) ? 6'd63 : fDiff[5:0];
        alTmp = {smlSig, 40'h0} >> fSh;
        // Bits shifted out are jammed into the lsb as a sticky bit.
        smlAl = alTmp[79:40] | {39'h0, |alTmp[39:0]};
        if (bigSgn == smlSgn) begin
            fMag = {1'b0, bigSig} + {1'b0, smlAl};
            fSgn = bigSgn;
        end else if (bigSig >= smlAl) begin
            fMag = {1'b0, bigSig} - {1'b0, smlAl};
            fSgn = bigSgn;
        end else begin
            fMag = {1'b0, smlAl} - {1'b0, bigSig};
            fSgn = smlSgn;
        end
        fLead = 6'd0;
        for (int i = 0; i < 41; i++) begin
            if (fMag[i]) begin
                fLead = 6'(i);
            end
        end
        fNorm = fMag << (6'd40 - fLead);
        fExp  = fEbig + $signed({5'h00, fLead}) - 11'sd`MAS_BF_POINT;
        // Round to nearest, ties to even, once at the very end.
        rndUp = fNorm[32] && ((|fNorm[31:0]) || fNorm[33]);
        fMant = {1'b1, fNorm[39:33]} + {8'h00, rndUp};
        if (fMant[8]) begin
            fExp = fExp + 11'sd1;
        end
        if (special) begin
            fltOut = `MAS_BF_NAN;
        end else if (fMag == 41'h0) begin
            fltOut = 16'h0000;
        end else if (fExp >= 11'sd255) begin
            fltOut = {fSgn, `MAS_BF_EXP_MAX, 7'h00};
        end else if (fExp <= 11'sd0) begin
            fltOut = {fSgn, 15'h0000};
        end else begin
            fltOut = {fSgn, fExp[7:0],
                      fMant[8] ? 7'h00 : fMant[6:0]};
        end
    end

    always_comb begin
        st_next       = st_reg;
        st_next.valid = opEnable;
        if (opEnable) begin
            unique case (mode)
                MODE_NORMAL: st_next.result = normOut;
                MODE_DUAL:   st_next.result = dualOut;
                MODE_QUAD:   st_next.result = quadOut;
                MODE_FLOAT:  st_next.result = {32'h0000_0000, fltOut};
            endcase
        end
    end

    // The result register doubles as the accumulator.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_reg.result <= `MAS_RESULT_RST;
            st_reg.valid  <= `MAS_VALID_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign result      = st_reg.result;
    assign resultValid = st_reg.valid;
endmodule // multiply_add_slice

//--- dv/multiply_add_slice_checker.sv
// Port-level assertions for the multiply-add slice.
`timescale 1ns/1ps
`include "multiply_add_slice_cfg.svh"

module multiply_add_slice_checker #(
    parameter bit SIGNED_OPS = 1'b1
) (
    input wire logic                                sys_clk,
    input wire logic                                reset,
    input wire logic                                opEnable,
    input wire multiply_add_slice_pkg::slice_mode_t mode,
    input wire logic [`MAS_A_W-1:0]                 opA,
    input wire logic [`MAS_B_W-1:0]                 opB,
    input wire logic [`MAS_R_W-1:0]                 addend,
    input wire logic                                useAdder,
    input wire logic                                subtract,
    input wire logic                                accumulate,
    input wire logic [`MAS_SH_W-1:0]                shiftAmt,
    input wire logic [`MAS_R_W-1:0]                 result,
    input wire logic                                resultValid
);
    import multiply_add_slice_pkg::*;
    logic [47:0] prodN;
    logic [47:0] shN;
    logic [11:0] q0;
    logic [23:0] d1;
    always_comb begin
        if (SIGNED_OPS) begin
            prodN = $signed(opA) * $signed(opB);
            q0 = $signed(opA[6:0]) * $signed(opB[5:0]);
            d1 = $signed(opA[18:11]) * $signed(opB[17:10]);
            shN = $signed(prodN) >>> shiftAmt;
        end else begin
            prodN = opA * opB;
            q0 = opA[6:0] * opB[5:0];
            d1 = opA[18:11] * opB[17:10];
            shN = prodN >> shiftAmt;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence normalOp;
        opEnable && mode == MODE_NORMAL && shiftAmt == 4'h0;
    endsequence
    sequence plainOp;
        opEnable && !useAdder && !accumulate && shiftAmt == 4'h0;
    endsequence
    a_valid_pulse: assert property (resultValid == $past(opEnable && !reset))
        else $error("valid pulse wrong");
    a_hold_idle: assert property (!opEnable |=> result == $past(result))
        else $error("result moved while idle");
    a_reset_clear: assert property ($past(reset) |-> result == 48'h0 && !resultValid)
        else $error("reset did not clear");
    a_mac_add: assert property (normalOp ##0 (useAdder && !subtract && !accumulate) |=> result == $past(addend + prodN))
        else $error("normal add wrong");
    a_acc_sub: assert property (normalOp ##0 (accumulate && subtract) |=> result == $past(result) - $past(prodN))
        else $error("accumulate subtract wrong");
    a_shift_lane: assert property (opEnable && mode == MODE_NORMAL && !useAdder && !accumulate |=> result == $past(shN))
        else $error("normal shift wrong");
    a_quad_trunc: assert property (plainOp ##0 mode == MODE_QUAD |=> result[11:0] == $past(q0))
        else $error("quad lane0 wrong");
    a_dual_lane: assert property (plainOp ##0 mode == MODE_DUAL |=> result[47:24] == $past(d1))
        else $error("dual lane1 wrong");
    a_float_upper: assert property (opEnable && mode == MODE_FLOAT |=> result[47:16] == 32'h0)
        else $error("float upper bits set");
endmodule // multiply_add_slice_checker

//--- dv/fabric_user_model.sv
// Fabric user logic that feeds operands and controls to the slice.
`timescale 1ns/1ps
`include "multiply_add_slice_cfg.svh"

module fabric_user_model #(
    parameter bit SIGNED_OPS = 1'b1
) (
    input  wire logic                                sys_clk,
    output logic                                     opEnable,
    output multiply_add_slice_pkg::slice_mode_t      mode,
    output logic [`MAS_A_W-1:0]                      opA,
    output logic [`MAS_B_W-1:0]                      opB,
    output logic [`MAS_R_W-1:0]                      addend,
    output logic [2:0]                               ctl,
    output logic [`MAS_SH_W-1:0]                     shiftAmt
);
    import multiply_add_slice_pkg::*;
    initial begin
        opEnable = 1'b0;
        mode = MODE_NORMAL;
        opA = '0;
        opB = '0;
        addend = '0;
        ctl = 3'h0;
        shiftAmt = 4'h0;
    end
    // Ctl packs useAdder, subtract, accumulate; all lanes share one signedness.
    task automatic op(input slice_mode_t m, input logic [18:0] a,
                      input logic [17:0] b, input logic [47:0] d,
                      input logic [2:0] c, input logic [3:0] s);
        @(posedge sys_clk);
        #1;
        opEnable = 1'b1;
        mode = m;
        opA = a;
        opB = b;
        addend = d;
        ctl = c;
        shiftAmt = s;
    endtask
    // Idle operands are scrambled so a held result cannot lean on them.
    task automatic idle();
        @(posedge sys_clk);
        #1;
        opEnable = 1'b0;
        opA = ~opA;
        opB = ~opB;
        addend = ~addend;
    endtask
endmodule // fabric_user_model

//--- dv/multiply_add_slice_tb_top.sv
// Self-checking testbench for the multiply-add slice.
`timescale 1ns/1ps
`include "multiply_add_slice_cfg.svh"

module multiply_add_slice_tb_top;
    import multiply_add_slice_pkg::*;
    logic        sys_clk;
    logic        reset;
    logic        opEnable;
    slice_mode_t mode;
    logic [18:0] opA;
    logic [17:0] opB;
    logic [47:0] addend;
    logic [2:0]  ctl;
    logic [3:0]  shiftAmt;
    logic [47:0] result;
    logic        resultValid;
    int          fail_count = 0;
    int          checks_done = 0;

    fabric_user_model fabric (.sys_clk(sys_clk), .opEnable(opEnable),
        .mode(mode), .opA(opA), .opB(opB), .addend(addend), .ctl(ctl),
        .shiftAmt(shiftAmt));
    multiply_add_slice dut (.sys_clk(sys_clk), .reset(reset),
        .opEnable(opEnable), .mode(mode), .opA(opA), .opB(opB),
        .addend(addend), .useAdder(ctl[2]), .subtract(ctl[1]),
        .accumulate(ctl[0]), .shiftAmt(shiftAmt), .result(result),
        .resultValid(resultValid));

    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic t_walk();
        fabric.op(MODE_NORMAL, 19'h3, 18'h5, 48'hA, 3'h4, 4'h0);
        fabric.op(MODE_NORMAL, 19'h3, 18'h5, 48'hA, 3'h5, 4'h0);
        check(result, 48'h19);
        fabric.op(MODE_NORMAL, 19'h3, 18'h5, 48'hA, 3'h7, 4'h0);
        check(result, 48'h28);
        fabric.idle();
        check(result, 48'h19);
        check(48'(resultValid), 48'h1);
        fabric.idle();
        check(result, 48'h19);
        check(48'(resultValid), 48'h0);
        $display("test walk done");
    endtask
    task automatic t_normal();
        fabric.op(MODE_NORMAL, 19'h40000, 18'h20000, 48'h0, 3'h6, 4'h0);
        fabric.op(MODE_NORMAL, 19'h40000, 18'h20000, 48'h0, 3'h0, 4'h4);
        check(result, 48'hFFF8_0000_0000);
        fabric.idle();
        check(result, 48'h0000_8000_0000);
        $display("test normal done");
    endtask
    task automatic t_dual_quad();
        fabric.op(MODE_DUAL, 19'h40400, 18'h1FFFF, 48'h0, 3'h0, 4'h0);
        fabric.op(MODE_QUAD, 19'h0BC40, 18'h06220, 48'h0, 3'h0, 4'h0);
        check(result, 48'hFFC0_8000_0400);
        fabric.op(MODE_QUAD, 19'h0BC40, 18'h06220, 48'h0, 3'h0, 4'h4);
        check(result, 48'h001F_C804_0800);
        fabric.idle();
        check(result, 48'h000F_FC00_4F80);
        $display("test dual quad done");
    endtask
    task automatic t_float();
        fabric.op(MODE_FLOAT, 19'h3FC0, 18'h4000, 48'h3F80, 3'h4, 4'h0);
        fabric.op(MODE_FLOAT, 19'h3FC0, 18'h4000, 48'h3F80, 3'h6, 4'h0);
        check(result, 48'h4080);
        fabric.op(MODE_FLOAT, 19'h7F80, 18'h4000, 48'h3F80, 3'h4, 4'h0);
        check(result, 48'hC000);
        fabric.idle();
        check(result, 48'h7FC0);
        $display("test float done");
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        #5000;
        fail_count++;
        close_out();
    end
    initial begin
        reset = 1'b1;
        repeat (16) @(posedge sys_clk);
        #1;
        reset = 1'b0;
        t_walk();
        t_normal();
        t_dual_quad();
        t_float();
        close_out();
    end
endmodule // multiply_add_slice_tb_top

bind multiply_add_slice multiply_add_slice_checker #(.SIGNED_OPS(SIGNED_OPS))
    chk (.sys_clk(sys_clk), .reset(reset), .opEnable(opEnable),
    .mode(mode), .opA(opA), .opB(opB), .addend(addend),
    .useAdder(useAdder), .subtract(subtract), .accumulate(accumulate),
    .shiftAmt(shiftAmt), .result(result), .resultValid(resultValid));
